// File: hdl/fidsp_map.vh
// constants for the flash identification and sector protect host controller
`ifndef FIDSP_MAP_VH
`define FIDSP_MAP_VH
`define FIDSP_CLK_PERIOD_NS   50
`define FIDSP_GLITCH_NS       5
`define FIDSP_SETUP_NS        100
`define FIDSP_STROBE_NS       150
`define FIDSP_HOLD_NS         100
`define FIDSP_SETUP_CYC       ((`FIDSP_SETUP_NS + `FIDSP_CLK_PERIOD_NS - 1) / `FIDSP_CLK_PERIOD_NS)
`define FIDSP_STROBE_CYC      ((`FIDSP_STROBE_NS + `FIDSP_CLK_PERIOD_NS - 1) / `FIDSP_CLK_PERIOD_NS)
`define FIDSP_HOLD_CYC        ((`FIDSP_HOLD_NS + `FIDSP_CLK_PERIOD_NS - 1) / `FIDSP_CLK_PERIOD_NS)
`define FIDSP_SECTOR_LSB      16
`define FIDSP_ADDR_W          21
`define FIDSP_UNLOCK1_ADDR    21'h00_0555
`define FIDSP_UNLOCK2_ADDR    21'h00_02AA
`define FIDSP_UNLOCK1_DATA    8'hAA
`define FIDSP_UNLOCK2_DATA    8'h55
`define FIDSP_AUTOSEL_DATA    8'h90
`define FIDSP_RESET_DATA      8'hF0
`define FIDSP_PROT_DATA       8'h01
`define FIDSP_UNPROT_DATA     8'h00
`define FIDSP_LAST_SECTOR     5'h1F
`define FIDSP_MAKER_ADDR      21'h00_0000
`define FIDSP_PART_ADDR       21'h00_0001
`define FIDSP_PROT_ADDR       21'h00_0002
`define FIDSP_OP_READ         3'h0
`define FIDSP_OP_WRITE        3'h1
`define FIDSP_OP_ID_HV        3'h2
`define FIDSP_OP_ID_CMD       3'h3
`define FIDSP_OP_PROT_HV      3'h4
`define FIDSP_OP_PROT_CMD     3'h5
`endif

// File: hdl/fidsp_bus_cycle.v
// one timed asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
`include "fidsp_map.vh"
module fidsp_bus_cycle
(
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        cyc_start,
    input  wire        cyc_write,
    input  wire [20:0] cyc_addr,
    input  wire [7:0]  cyc_wdata,
    input  wire [7:0]  byte_lines_in,
    output wire        cyc_done,
    output reg  [7:0]  cyc_rdata,
    output reg  [20:0] addr_out,
    output reg  [7:0]  byte_lines_out,
    output reg         byte_lines_oe_n,
    output reg         chip_sel_n,
    output reg         out_en_n,
    output reg         wr_en_n
);
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_SETUP = 2'd1;
    localparam [1:0] ST_STRB  = 2'd2;
    localparam [1:0] ST_HOLD  = 2'd3;
    localparam integer SETUP_I = `FIDSP_SETUP_CYC;
    localparam integer STRB_I  = `FIDSP_STROBE_CYC;
    localparam integer HOLD_I  = `FIDSP_HOLD_CYC;
    localparam [3:0] SETUP_C  = SETUP_I[3:0];
    localparam [3:0] STRB_C   = STRB_I[3:0];
    localparam [3:0] HOLD_C   = HOLD_I[3:0];
    reg [1:0] st_reg;
    reg [3:0] cnt_reg;
    reg       wr_reg;
    reg [7:0] sync1_reg;
    reg [7:0] sync2_reg;
    assign cyc_done = (st_reg == ST_HOLD) && (cnt_reg == 4'h1);
    always @(posedge mclk)
    begin
        sync1_reg <= byte_lines_in;
        sync2_reg <= sync1_reg;
    end
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_reg          <= ST_IDLE;
            cnt_reg         <= 4'h0;
            wr_reg          <= 1'b0;
            cyc_rdata       <= 8'h00;
            addr_out        <= 21'h00_0000;
            byte_lines_out  <= 8'h00;
            byte_lines_oe_n <= 1'b1;
            chip_sel_n      <= 1'b1;
            out_en_n        <= 1'b1;
            wr_en_n         <= 1'b1;
        end
        else
        begin
            case (st_reg)
                ST_IDLE:
                begin
                    if (cyc_start)
                    begin
                        addr_out        <= cyc_addr;
                        wr_reg          <= cyc_write;
                        byte_lines_out  <= cyc_wdata;
                        byte_lines_oe_n <= ~cyc_write;
                        chip_sel_n      <= 1'b0;
                        cnt_reg         <= SETUP_C;
                        st_reg          <= ST_SETUP;
                    end
                end
                ST_SETUP:
                begin
                    if (cnt_reg == 4'h1)
                    begin
                        // write: oe high, we low; read: oe low, we high
                        wr_en_n  <= ~wr_reg;
                        out_en_n <= wr_reg;
                        cnt_reg  <= STRB_C;
                        st_reg   <= ST_STRB;
                    end
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                end
                ST_STRB:
                begin
                    if (cnt_reg == 4'h1)
                    begin
                        cyc_rdata <= sync2_reg;
                        wr_en_n   <= 1'b1;
                        out_en_n  <= 1'b1;
                        cnt_reg   <= HOLD_C;
                        st_reg    <= ST_HOLD;
                    end
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                end
                ST_HOLD:
                begin
                    if (cnt_reg == 4'h1)
                    begin
                        chip_sel_n      <= 1'b1;
                        byte_lines_oe_n <= 1'b1;
                        st_reg          <= ST_IDLE;
                    end
                    else
                        cnt_reg <= cnt_reg - 4'h1;
                end
                default:
                    st_reg <= ST_IDLE;
            endcase
        end
    end
endmodule // fidsp_bus_cycle

// File: hdl/fidsp_host.v
// host controller for flash identification, protect verify and writes
`timescale 1ns/1ps
`include "fidsp_map.vh"
// Functional notes
// - high-voltage id read raises id strobe line, sets low address selectors.
// - protect verify puts sector on top bits, address bit one high.
// - primary protect method raises only the reset pin, normal bus timing; the host raises that pin only for temporary unprotect.
// - all unprotected sectors must be protected before first unprotect write.
// - programmer protect method raises id strobe line and output enable.
// - program and erase need the unlock write cycles first.
// - below lockout the host keeps control pins from unintended writes.
// - five top address bits select one of thirty-two sectors.
module fidsp_host
(
    input  wire        mclk,
    input  wire        sys_rst,
    input  wire        req_valid,
    input  wire [2:0]  req_op,
    input  wire [20:0] req_addr,
    input  wire [7:0]  req_wdata,
    input  wire        req_temp_unprot,
    input  wire        req_prot_hv,
    input  wire        supply_ok,
    output wire        req_ready,
    output reg         rsp_valid,
    output reg  [7:0]  rsp_data,
    output reg         rsp_protected,
    input  wire [7:0]  byte_lines_in,
    output wire [7:0]  byte_lines_out,
    output wire        byte_lines_oe_n,
    output wire [20:0] flash_addr,
    output wire        chip_sel_n,
    output wire        out_en_n,
    output wire        wr_en_n,
    output reg         id_strobe_hv_en,
    output reg         out_en_hv_en,
    output reg         reset_hv_en,
    output reg         flash_rst_n
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_RUN  = 3'd1;
    localparam [2:0] ST_WAIT = 3'd2;
    localparam [2:0] ST_RESP = 3'd3;
    localparam [2:0] ST_LOCK = 3'd4;
    reg [2:0]  st_reg;
    reg [2:0]  op_reg;
    reg [2:0]  step_reg;
    reg [20:0] addr_reg;
    reg [7:0]  wdata_reg;
    reg        cyc_start;
    reg        cyc_write;
    reg [20:0] cyc_addr;
    reg [7:0]  cyc_wdata;
    reg        last_step;
    reg        ok1_reg;
    reg        ok2_reg;
    reg        sweep_reg;
    reg [4:0]  sec_reg;
    wire       cyc_done;
    wire [7:0] cyc_rdata;
    // number of bus cycles per operation
    function [2:0] op_steps;
        input [2:0] op;
        begin
            case (op)
                `FIDSP_OP_WRITE:    op_steps = 3'd3;
                `FIDSP_OP_ID_CMD:   op_steps = 3'd5;
                `FIDSP_OP_PROT_CMD: op_steps = 3'd5;
                default:            op_steps = 3'd1;
            endcase
        end
    endfunction
    // high-voltage id strobe needed by this operation
    function hv_op;
        input [2:0] op;
        begin
            hv_op = (op == `FIDSP_OP_ID_HV) || (op == `FIDSP_OP_PROT_HV);
        end
    endfunction
    assign req_ready = (st_reg == ST_IDLE) && ok2_reg;
    always @(posedge mclk)
    begin
        ok1_reg <= supply_ok;
        ok2_reg <= ok1_reg;
    end
    // cycle sequencer: unlock, command, then access
    always @*
    begin
        cyc_start = (st_reg == ST_RUN);
        cyc_write = 1'b0;
        cyc_addr  = addr_reg;
        cyc_wdata = wdata_reg;
        last_step = !sweep_reg && (step_reg == op_steps(op_reg) - 3'd1);
        case (op_reg)
            `FIDSP_OP_WRITE, `FIDSP_OP_ID_CMD, `FIDSP_OP_PROT_CMD:
            begin
                case (step_reg)
                    3'd0:
                    begin
                        cyc_write = 1'b1;
                        cyc_addr  = `FIDSP_UNLOCK1_ADDR;
                        cyc_wdata = `FIDSP_UNLOCK1_DATA;
                    end
                    3'd1:
                    begin
                        cyc_write = 1'b1;
                        cyc_addr  = `FIDSP_UNLOCK2_ADDR;
                        cyc_wdata = `FIDSP_UNLOCK2_DATA;
                    end
                    3'd2:
                    begin
                        cyc_write = 1'b1;
                        if (op_reg != `FIDSP_OP_WRITE)
                        begin
                            cyc_addr  = `FIDSP_UNLOCK1_ADDR;
                            cyc_wdata = `FIDSP_AUTOSEL_DATA;
                        end
                    end
                    3'd3:
                    begin
                        if (op_reg == `FIDSP_OP_PROT_CMD)
                            cyc_addr = {addr_reg[20:16], 16'h0002};
                        else
                            cyc_addr = {20'h0_0000, addr_reg[0]};
                    end
                    default:
                    begin
                        cyc_write = 1'b1;
                        cyc_addr  = 21'h00_0000;
                        cyc_wdata = `FIDSP_RESET_DATA;
                    end
                endcase
            end
            `FIDSP_OP_ID_HV:
                cyc_addr = {20'h0_0000, addr_reg[0]};
            `FIDSP_OP_PROT_HV:
                cyc_addr = {addr_reg[20:16], 16'h0002};
            default:
                cyc_addr = addr_reg;
        endcase
        // protect every sector before an unprotect write
        if (sweep_reg)
        begin
            cyc_write = 1'b1;
            cyc_addr  = {sec_reg, 16'h0000};
            cyc_wdata = `FIDSP_PROT_DATA;
        end
    end
    always @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_reg          <= ST_IDLE;
            op_reg          <= `FIDSP_OP_READ;
            step_reg        <= 3'd0;
            addr_reg        <= 21'h00_0000;
            wdata_reg       <= 8'h00;
            rsp_valid       <= 1'b0;
            rsp_data        <= 8'h00;
            rsp_protected   <= 1'b0;
            id_strobe_hv_en <= 1'b0;
            out_en_hv_en    <= 1'b0;
            reset_hv_en     <= 1'b0;
            flash_rst_n     <= 1'b0;
            sweep_reg       <= 1'b0;
            sec_reg         <= 5'h00;
        end
        else
        begin
            rsp_valid    <= 1'b0;
            reset_hv_en  <= req_temp_unprot;
            out_en_hv_en <= req_prot_hv;
            flash_rst_n  <= ok2_reg;
            case (st_reg)
                ST_IDLE:
                begin
                    if (!ok2_reg)
                        st_reg <= ST_LOCK;
                    else if (req_valid)
                    begin
                        op_reg          <= req_op;
                        addr_reg        <= req_addr;
                        wdata_reg       <= req_wdata;
                        step_reg        <= 3'd0;
                        id_strobe_hv_en <= hv_op(req_op) | req_prot_hv;
                        sec_reg         <= 5'h00;
                        sweep_reg       <= (req_op == `FIDSP_OP_WRITE) && req_prot_hv
                                           && (req_wdata == `FIDSP_UNPROT_DATA);
                        st_reg          <= ST_RUN;
                    end
                end
                ST_RUN:
                    st_reg <= ST_WAIT;
                ST_WAIT:
                begin
                    if (cyc_done)
                    begin
                        if (last_step)
                            st_reg <= ST_RESP;
                        else if (sweep_reg)
                        begin
                            sweep_reg <= (sec_reg != `FIDSP_LAST_SECTOR);
                            sec_reg   <= sec_reg + 5'h01;
                            st_reg    <= ST_RUN;
                        end
                        else
                        begin
                            step_reg <= step_reg + 3'd1;
                            st_reg   <= ST_RUN;
                        end
                        if (!cyc_write)
                        begin
                            rsp_data      <= cyc_rdata;
                            rsp_protected <= cyc_rdata[0];
                        end
                    end
                end
                ST_RESP:
                begin
                    rsp_valid       <= 1'b1;
                    id_strobe_hv_en <= 1'b0;
                    st_reg          <= ST_IDLE;
                end
                ST_LOCK:
                begin
                    if (ok2_reg)
                        st_reg <= ST_IDLE;
                end
                default:
                    st_reg <= ST_IDLE;
            endcase
        end
    end
    fidsp_bus_cycle u_cycle
    (
        .mclk            (mclk),
        .sys_rst         (sys_rst),
        .cyc_start       (cyc_start),
        .cyc_write       (cyc_write),
        .cyc_addr        (cyc_addr),
        .cyc_wdata       (cyc_wdata),
        .byte_lines_in   (byte_lines_in),
        .cyc_done        (cyc_done),
        .cyc_rdata       (cyc_rdata),
        .addr_out        (flash_addr),
        .byte_lines_out  (byte_lines_out),
        .byte_lines_oe_n (byte_lines_oe_n),
        .chip_sel_n      (chip_sel_n),
        .out_en_n        (out_en_n),
        .wr_en_n         (wr_en_n)
    );
endmodule // fidsp_host

// File: bench/fidsp_props.sv
// concurrent checks on the host controller ports
`timescale 1ns/1ps
module fidsp_props
(
    input wire        mclk,
    input wire        sys_rst,
    input wire        supply_ok,
    input wire        req_temp_unprot,
    input wire        req_ready,
    input wire [7:0]  byte_lines_out,
    input wire        byte_lines_oe_n,
    input wire [20:0] flash_addr,
    input wire        chip_sel_n,
    input wire        out_en_n,
    input wire        wr_en_n,
    input wire        reset_hv_en,
    input wire        flash_rst_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_write_gate: assert property (!wr_en_n |-> !chip_sel_n && out_en_n)
        else $error("write strobe outside chip select or with output enable low");
    a_read_gate: assert property (!out_en_n |-> !chip_sel_n && wr_en_n && byte_lines_oe_n)
        else $error("read strobe with bad control levels");
    a_wr_width: assert property ($fell(wr_en_n) |-> !wr_en_n[*3] ##1 wr_en_n)
        else $error("write strobe width wrong");
    a_rd_width: assert property ($fell(out_en_n) |-> !out_en_n[*3] ##1 out_en_n)
        else $error("read strobe width wrong");
    a_wr_stable: assert property (!wr_en_n |->
        !byte_lines_oe_n && $stable(flash_addr) && $stable(byte_lines_out))
        else $error("address or data moved during write strobe");
    a_cs_frame: assert property ($rose(chip_sel_n) |-> out_en_n && wr_en_n)
        else $error("chip select released before strobes");
    a_lock_ready: assert property (!supply_ok |-> ##[1:3] !req_ready)
        else $error("requests accepted during lockout");
    a_lock_rst: assert property (!supply_ok |-> ##[1:4] !flash_rst_n)
        else $error("flash not reset during lockout");
    a_temp_unprot: assert property (reset_hv_en == $past(req_temp_unprot))
        else $error("reset pin elevation does not follow request");
endmodule // fidsp_props
bind fidsp_host fidsp_props u_props (.mclk, .sys_rst, .supply_ok, .req_temp_unprot,
    .req_ready, .byte_lines_out, .byte_lines_oe_n, .flash_addr, .chip_sel_n,
    .out_en_n, .wr_en_n, .reset_hv_en, .flash_rst_n);

// File: bench/fidsp_flash_model.sv
// behavioural model of the flash identification and protect logic
`timescale 1ns/1ps
module fidsp_flash_model
#(
    parameter [7:0] MAKER_ID = 8'h3C, // arbitrary value
    parameter [7:0] PART_ID  = 8'h5A  // arbitrary value
)
(
    input  wire [20:0] flash_addr,
    input  wire [7:0]  byte_lines_out,
    input  wire        byte_lines_oe_n,
    input  wire        chip_sel_n,
    input  wire        out_en_n,
    input  wire        wr_en_n,
    input  wire        id_strobe_hv_en,
    input  wire        out_en_hv_en,
    input  wire        reset_hv_en,
    input  wire        flash_rst_n,
    output wire [7:0]  byte_lines_in
);
    logic [31:0] prot_reg = 32'h0000_0000;
    logic [7:0]  mem [0:(1<<21)-1];
    logic [1:0]  cnt_reg = 2'h0;
    logic        autosel_reg = 1'b0;
    logic        armed_reg = 1'b0;
    logic        order_bad = 1'b0;
    logic        cyc_reg = 1'b0;
    logic [20:0] addr_lat;
    logic [7:0]  last_reg = 8'h00;
    realtime     t_fall;
    wire         idm = id_strobe_hv_en | autosel_reg;
    wire  [7:0]  idv = flash_addr[1] ? {7'h00, prot_reg[flash_addr[20:16]]}
                     : (flash_addr[0] ? PART_ID : MAKER_ID);
    wire  [7:0]  val = idm ? idv : mem[flash_addr];
    wire         rd = !chip_sel_n && !out_en_n && wr_en_n && flash_rst_n;
    assign byte_lines_in = rd ? val : ~last_reg;
    always @(posedge out_en_n) last_reg <= val;
    always @(negedge wr_en_n or negedge chip_sel_n)
        if (!wr_en_n && !chip_sel_n)
        begin
            addr_lat = flash_addr;
            t_fall = $realtime;
            cyc_reg = 1'b1;
            armed_reg = 1'b1;
        end
    always @(posedge wr_en_n or posedge chip_sel_n)
    begin
        if (cyc_reg && ($realtime - t_fall >= 5.0) && (out_en_n || out_en_hv_en)
            && flash_rst_n && armed_reg)
            wr(addr_lat, byte_lines_out);
        cyc_reg = 1'b0;
    end
    always @(negedge flash_rst_n)
    begin
        cnt_reg = 2'h0;
        autosel_reg = 1'b0;
        cyc_reg = 1'b0;
    end
    task wr(input [20:0] a, input [7:0] d);
        if (out_en_hv_en && id_strobe_hv_en)
        begin
            if (d == 8'h01) prot_reg[a[20:16]] = 1'b1;
            else if (d == 8'h00)
            begin
                if (prot_reg != 32'hFFFF_FFFF) order_bad = 1'b1;
                prot_reg = 32'h0000_0000;
            end
        end
        else if (cnt_reg == 2'h2)
        begin
            cnt_reg = 2'h0;
            if (d == 8'h90) autosel_reg = 1'b1;
            else if (d == 8'hF0) autosel_reg = 1'b0;
            else if (!prot_reg[a[20:16]] || reset_hv_en) mem[a] = d;
        end
        else if (d == 8'hF0) {cnt_reg, autosel_reg} = 3'h0;
        else if (cnt_reg == 2'h0 && a == 21'h00_0555 && d == 8'hAA) cnt_reg = 2'h1;
        else if (cnt_reg == 2'h1 && a == 21'h00_02AA && d == 8'h55) cnt_reg = 2'h2;
        else cnt_reg = 2'h0;
    endtask
endmodule // fidsp_flash_model

// File: bench/testbench.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module testbench;
    localparam [7:0] MAKER = 8'h3C; // arbitrary value
    localparam [7:0] PART = 8'h5A; // arbitrary value
    reg mclk = 0, sys_rst = 1, req_valid = 0, req_temp_unprot = 0, req_prot_hv = 0, supply_ok = 1;
    reg [2:0] req_op = 0;
    reg [20:0] req_addr = 0, a;
    reg [7:0] req_wdata = 0;
    wire req_ready, rsp_valid, rsp_protected, byte_lines_oe_n, chip_sel_n, out_en_n, wr_en_n;
    wire id_strobe_hv_en, out_en_hv_en, reset_hv_en, flash_rst_n;
    wire [7:0] rsp_data, byte_lines_in, byte_lines_out;
    wire [20:0] flash_addr;
    integer num_errors = 0, checked = 0, i;
    reg [31:0] seed = 43593, r;
    reg [9:0] q[$];
    reg [9:0] nt;
    always #25 mclk = ~mclk;
    fidsp_host u_dut (.mclk, .sys_rst, .req_valid, .req_op, .req_addr, .req_wdata,
        .req_temp_unprot, .req_prot_hv, .supply_ok, .req_ready, .rsp_valid, .rsp_data,
        .rsp_protected, .byte_lines_in, .byte_lines_out, .byte_lines_oe_n, .flash_addr,
        .chip_sel_n, .out_en_n, .wr_en_n, .id_strobe_hv_en, .out_en_hv_en, .reset_hv_en,
        .flash_rst_n);
    fidsp_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash (.flash_addr,
        .byte_lines_out, .byte_lines_oe_n, .chip_sel_n, .out_en_n, .wr_en_n,
        .id_strobe_hv_en, .out_en_hv_en, .reset_hv_en, .flash_rst_n, .byte_lines_in);
    function [31:0] rnd;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        rnd = seed;
    endfunction
    task conclude;
        if (num_errors == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task cmp8(input [7:0] e, input [7:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH rsp_data exp %h got %h", e, g);
        end
    endtask
    task cmp1(input string n, input e, input g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("MISMATCH %s exp %b got %b", n, e, g);
        end
    endtask
    task op(input [2:0] o, input [20:0] ad, input [7:0] wd, input [1:0] c, input [7:0] e);
        integer n;
        n = 0;
        @(posedge mclk);
        {req_valid, req_op, req_addr, req_wdata} <= {1'b1, o, ad, wd};
        @(negedge mclk);
        while (req_ready !== 1'b1 && n < 500)
        begin
            @(negedge mclk);
            n++;
        end
        @(posedge mclk);
        req_valid <= 1'b0;
        q.push_back({c, e});
        while (q.size() > 0 && n < 500)
        begin
            @(posedge mclk);
            n++;
        end
        if (n >= 500)
        begin
            num_errors++;
            conclude;
        end
    endtask
    always @(posedge mclk)
        if (rsp_valid === 1'b1)
        begin
            if (q.size() == 0)
                cmp1("rsp_valid", 1'b0, rsp_valid);
            else
            begin
                nt = q.pop_front();
                if (nt[9]) cmp8(nt[7:0], rsp_data);
                if (nt[8]) cmp1("rsp_protected", nt[0], rsp_protected);
            end
        end
    initial
    begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        op(2, 21'h0, 0, 2, MAKER);
        op(2, 21'h1, 0, 2, PART);
        op(3, 21'h0, 0, 2, MAKER);
        op(3, 21'h1, 0, 2, PART);
        for (i = 0; i < 32; i++) op(4, {i[4:0], 16'h0000}, 0, 3, 0);
        repeat (4)
        begin
            r = rnd();
            op(1, r[20:0], r[31:24] & 8'h7F, 0, 0);
            op(0, r[20:0], 0, 2, r[31:24] & 8'h7F);
        end
        r = rnd();
        a = r[20:0];
        op(1, a, 8'h3C, 0, 0);
        req_prot_hv <= 1'b1;
        op(1, a, 8'h01, 0, 0);
        req_prot_hv <= 1'b0;
        op(5, {a[20:16], 16'h0000}, 0, 3, 1);
        op(1, a, 8'h11, 0, 0);
        op(0, a, 0, 2, 8'h3C);
        req_temp_unprot <= 1'b1;
        op(1, a, 8'h22, 0, 0);
        op(0, a, 0, 2, 8'h22);
        req_temp_unprot <= 1'b0;
        op(1, a, 8'h33, 0, 0);
        op(4, {a[20:16], 16'h0000}, 0, 3, 1);
        op(0, a, 0, 2, 8'h22);
        req_prot_hv <= 1'b1;
        op(1, a, 8'h00, 0, 0);
        cmp1("unprot_order", 1'b0, u_flash.order_bad);
        req_prot_hv <= 1'b0;
        op(4, {~a[20:16], 16'h0000}, 0, 3, 0);
        op(1, a, 8'h66, 0, 0);
        op(0, a, 0, 2, 8'h66);
        @(posedge mclk);
        supply_ok <= 1'b0;
        repeat (5) @(negedge mclk);
        cmp1("req_ready", 1'b0, req_ready);
        cmp1("flash_rst_n", 1'b0, flash_rst_n);
        @(posedge mclk);
        supply_ok <= 1'b1;
        op(3, 21'h1, 0, 2, PART);
        conclude;
    end
endmodule // testbench
